// file: core/sff_supply_flags.sv
`timescale 1ns/10ps
module sff_supply_flags #(
	parameter int SHORT_CYCLES = sff_pkg::SHORT_CYCLES
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic srst,
	input wire logic por_pulse,
	input wire logic soft_reset_pulse,
	// Operating state.
	input wire logic [2:0] op_mode,
	input wire logic main_reg_on,
	input wire logic reset_output_released,
	input wire logic failsafe_uv_entry,
	// Analog detector levels, asynchronous.
	input wire logic det_batt_uv,
	input wire logic det_r3_oc,
	input wire logic det_r3_uv,
	input wire logic det_r3_ot,
	input wire logic det_main_ov,
	input wire logic det_main_prewarn,
	input wire logic det_hs_uv,
	input wire logic det_hs_ov,
	input wire logic det_r2_ot,
	input wire logic det_r2_uv,
	input wire logic det_main_uv,
	// Command port.
	input wire logic cmd_valid,
	input wire logic [15:0] cmd_word,
	// Answer port.
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic [7:0] secondary_supply_fail_flags,
	output logic [7:0] primary_supply_fail_flags
);

	////////////////////////////////////////////////////////////////////////////////
	// Parameter checks.

	// The short timer needs at least one cycle.
	if (SHORT_CYCLES < 1)
	begin : g_bad_short
		$error("SHORT_CYCLES must be at least one.");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Detector synchronisers.

	localparam int NDET = 11;
	logic [NDET-1:0] det_raw; // Raw detector levels.
	logic [NDET-1:0] det_meta; // First synchroniser stage.
	logic [NDET-1:0] det_sync; // Second synchroniser stage.
	logic [NDET-1:0] next_det_meta; // Next first stage.
	logic [NDET-1:0] next_det_sync; // Next second stage.

	assign det_raw = {det_main_uv, det_r2_uv, det_r2_ot, det_hs_ov, det_hs_uv,
		det_main_prewarn, det_main_ov, det_r3_ot, det_r3_uv, det_r3_oc, det_batt_uv};

	// Shift the detectors two flip-flops deep.
	always_comb
	begin
		next_det_meta = det_raw;
		next_det_sync = det_meta;
	end

	// Register the synchroniser stages.
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			det_meta <= '0;
			det_sync <= '0;
		end
		else
		begin
			det_meta <= next_det_meta;
			det_sync <= next_det_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode qualification and short timer.

	logic [31:0] short_cnt; // Cycles of continuous main undervoltage.
	logic [31:0] next_short_cnt; // Next timer value.
	logic short_cond; // Main short condition present.
	logic mode_restart_q; // Restart mode seen last cycle.
	logic next_mode_restart_q; // Next restart history.
	logic [1:0] uv_run; // Consecutive undervoltage counter toward fail-safe.
	logic [1:0] next_uv_run; // Next run count.
	logic uv_prev; // Undervoltage level last cycle.
	logic next_uv_prev; // Next undervoltage history.
	logic main_gate; // Main flags may be set.
	logic uv_update; // Undervoltage flag may update.
	logic restart_entry; // First cycle of restart mode.
	logic uv_rise; // Rising edge of main undervoltage.

	// Decide when main regulator flags may be set.
	always_comb
	begin
		short_cond = (short_cnt >= 32'(SHORT_CYCLES));
		uv_rise = det_sync[10] && !uv_prev;
		// Sleep with the regulator off masks the main overvoltage, short and undervoltage flags.
		main_gate = !((op_mode == 3'(sff_pkg::SFF_MODE_SLEEP)) && !main_reg_on);
		case (op_mode)
			3'(sff_pkg::SFF_MODE_RESTART): uv_update = 1'b0;
			3'(sff_pkg::SFF_MODE_INIT): uv_update = reset_output_released;
			3'(sff_pkg::SFF_MODE_NORMAL), 3'(sff_pkg::SFF_MODE_STOP): uv_update = 1'b1;
			default: uv_update = 1'b0;
		endcase
		// A short condition overrides the mode restriction.
		if (short_cond)
		begin
			uv_update = 1'b1;
		end
		uv_update = uv_update && main_gate;
		restart_entry = (op_mode == 3'(sff_pkg::SFF_MODE_RESTART)) && !mode_restart_q;
		next_mode_restart_q = (op_mode == 3'(sff_pkg::SFF_MODE_RESTART));
		next_uv_prev = det_sync[10];
		// Count how long undervoltage has persisted, saturating at the limit.
		if (!det_sync[10])
		begin
			next_short_cnt = '0;
		end
		else if (!short_cond)
		begin
			next_short_cnt = short_cnt + 32'd1;
		end
		else
		begin
			next_short_cnt = short_cnt;
		end
		// Count undervoltage events; clean normal operation resets the run.
		// This run count is kept for diagnosis only and drives no flag.
		// The fourth-event decision is made outside and arrives as a level,
		// so the fail-safe flag never depends on this counter wrapping.
		if (uv_rise && uv_run != 2'(sff_pkg::FS_UV_COUNT - 1))
		begin
			next_uv_run = uv_run + 2'd1;
		end
		else if (uv_rise)
		begin
			next_uv_run = '0;
		end
		else if (op_mode == 3'(sff_pkg::SFF_MODE_NORMAL) && !det_sync[10])
		begin
			next_uv_run = '0;
		end
		else
		begin
			next_uv_run = uv_run;
		end
	end

	// Register qualification state.
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			short_cnt <= '0;
			mode_restart_q <= 1'b0;
			uv_run <= '0;
			uv_prev <= 1'b0;
		end
		else
		begin
			short_cnt <= next_short_cnt;
			mode_restart_q <= next_mode_restart_q;
			uv_run <= next_uv_run;
			uv_prev <= next_uv_prev;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Flag registers and command handling.

	logic [7:0] sec_set; // Secondary set requests.
	logic [7:0] pri_set; // Primary set requests.
	logic [7:0] sec_clr; // Secondary clear mask.
	logic [7:0] pri_clr; // Primary clear mask.
	logic [6:0] cmd_addr; // Command address field.
	logic cmd_clear; // Command access bit.
	logic [7:0] next_sec; // Next secondary value.
	logic [7:0] next_pri; // Next primary value.
	logic next_rsp_valid; // Next answer strobe.
	logic [7:0] next_rsp_data; // Next answer byte.

	// Build set and clear masks and the next register values.
	// Set terms are ORed in after the clear mask, so an event that is
	// present in the clear cycle is never lost by the host's clear.
	always_comb
	begin
		cmd_addr = cmd_word[sff_pkg::CMD_ADDR_MSB:sff_pkg::CMD_ADDR_LSB];
		cmd_clear = cmd_word[sff_pkg::CMD_ACCESS_BIT];
		sec_set = '0;
		sec_set[sff_pkg::SEC_BATT_UV] = det_sync[0];
		sec_set[sff_pkg::SEC_R3_OC] = det_sync[1];
		sec_set[sff_pkg::SEC_R3_UV] = det_sync[2];
		sec_set[sff_pkg::SEC_R3_OT] = det_sync[3];
		sec_set[sff_pkg::SEC_MAIN_OV] = det_sync[4] && main_gate;
		sec_set[sff_pkg::SEC_MAIN_WARN] = det_sync[5];
		pri_set = '0;
		pri_set[sff_pkg::PRI_HS_UV] = det_sync[6];
		pri_set[sff_pkg::PRI_HS_OV] = det_sync[7];
		pri_set[sff_pkg::PRI_R2_OT] = det_sync[8];
		pri_set[sff_pkg::PRI_R2_UV] = det_sync[9];
		pri_set[sff_pkg::PRI_MAIN_SC] = short_cond && main_gate;
		pri_set[sff_pkg::PRI_FS_UV] = failsafe_uv_entry;
		pri_set[sff_pkg::PRI_MAIN_UV] = det_sync[10] && uv_update;
		// Only a clear command or a reset removes flags, except restart entry, which drops the fail-safe flag unless it is set again.
		sec_clr = '0;
		pri_clr = '0;
		if (cmd_valid && cmd_clear && cmd_addr == sff_pkg::ADDR_SECONDARY)
		begin
			sec_clr = 8'hff;
		end
		if (cmd_valid && cmd_clear && cmd_addr == sff_pkg::ADDR_PRIMARY)
		begin
			pri_clr = 8'hff;
		end
		// Set wins over clear in the same cycle.
		next_sec = ((secondary_supply_fail_flags & ~sec_clr) | sec_set)
			& sff_pkg::SEC_IMPL_MASK;
		next_pri = (primary_supply_fail_flags & ~pri_clr) | pri_set;
		if (restart_entry)
		begin
			next_pri[sff_pkg::PRI_FS_UV] = pri_set[sff_pkg::PRI_FS_UV];
			next_sec = next_sec & sff_pkg::SEC_IMPL_MASK;
		end
		// Read answer shows the value before any clear.
		next_rsp_valid = cmd_valid;
		if (cmd_valid && cmd_addr == sff_pkg::ADDR_SECONDARY)
		begin
			next_rsp_data = secondary_supply_fail_flags & sff_pkg::SEC_IMPL_MASK;
		end
		else if (cmd_valid && cmd_addr == sff_pkg::ADDR_PRIMARY)
		begin
			next_rsp_data = primary_supply_fail_flags;
		end
		else if (cmd_valid)
		begin
			next_rsp_data = '0;
		end
		else
		begin
			next_rsp_data = rsp_data;
		end
	end

	// Register the flags; power-on and soft reset load their own values.
	always_ff @(posedge mclk)
	begin
		if (srst || por_pulse)
		begin
			secondary_supply_fail_flags <= sff_pkg::SEC_RESET;
			primary_supply_fail_flags <= sff_pkg::PRI_POR_RESET;
			rsp_valid <= 1'b0;
			rsp_data <= '0;
		end
		else if (soft_reset_pulse)
		begin
			secondary_supply_fail_flags <= sff_pkg::SEC_RESET;
			primary_supply_fail_flags <= sff_pkg::PRI_SOFT_RESET;
			rsp_valid <= 1'b0;
			rsp_data <= '0;
		end
		else
		begin
			secondary_supply_fail_flags <= next_sec;
			primary_supply_fail_flags <= next_pri;
			rsp_valid <= next_rsp_valid;
			rsp_data <= next_rsp_data;
		end
	end

endmodule : sff_supply_flags

// file: inc/sff_pkg.sv
package sff_pkg;

	// Register addresses, 7-bit, as carried in the command word.
	localparam logic [6:0] ADDR_SECONDARY = 7'h40;
	localparam logic [6:0] ADDR_PRIMARY = 7'h41;

	// Command word layout.
	localparam int CMD_ADDR_LSB = 0;
	localparam int CMD_ADDR_MSB = 6;
	localparam int CMD_ACCESS_BIT = 7;
	localparam int CMD_DATA_LSB = 8;
	localparam int CMD_DATA_MSB = 15;

	// Secondary register fields.
	localparam int SEC_BATT_UV = 6;
	localparam int SEC_R3_OC = 4;
	localparam int SEC_R3_UV = 3;
	localparam int SEC_R3_OT = 2;
	localparam int SEC_MAIN_OV = 1;
	localparam int SEC_MAIN_WARN = 0;
	localparam logic [7:0] SEC_IMPL_MASK = 8'h5f;
	localparam logic [7:0] SEC_RESET = 8'h00;

	// Primary register fields.
	localparam int PRI_POR = 7;
	localparam int PRI_HS_UV = 6;
	localparam int PRI_HS_OV = 5;
	localparam int PRI_R2_OT = 4;
	localparam int PRI_R2_UV = 3;
	localparam int PRI_MAIN_SC = 2;
	localparam int PRI_FS_UV = 1;
	localparam int PRI_MAIN_UV = 0;
	localparam logic [7:0] PRI_POR_RESET = 8'h80;
	localparam logic [7:0] PRI_SOFT_RESET = 8'h00;

	// Short-to-ground qualification time.
	localparam int SHORT_TIME_US = 4000;
	localparam int CLK_MHZ = 250;
	localparam int SHORT_CYCLES = SHORT_TIME_US * CLK_MHZ;

	// Fail-safe entry count of consecutive undervoltage events.
	localparam int FS_UV_COUNT = 4;

	// Operating modes.
	typedef enum logic [2:0] {
		SFF_MODE_INIT,
		SFF_MODE_NORMAL,
		SFF_MODE_STOP,
		SFF_MODE_SLEEP,
		SFF_MODE_RESTART
	} sff_mode_t;

endpackage : sff_pkg

// file: tb/sff_supply_flags_checker.sv
`timescale 1ns/10ps
module sff_supply_flags_checker #(parameter int SHORT_CYCLES = 20) (
	// Clock, resets and operating state.
	input wire logic mclk, srst, por_pulse, soft_reset_pulse,
	input wire logic [2:0] op_mode,
	input wire logic main_reg_on, reset_output_released, failsafe_uv_entry,
	// Detector levels.
	input wire logic det_batt_uv, det_r3_oc, det_r3_uv, det_r3_ot, det_main_ov,
	input wire logic det_main_prewarn, det_hs_uv, det_hs_ov, det_r2_ot, det_r2_uv, det_main_uv,
	// Command and answer.
	input wire logic cmd_valid,
	input wire logic [15:0] cmd_word,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_data, secondary_supply_fail_flags, primary_supply_fail_flags
);
	// Short aliases and decoded commands.
	wire [7:0] s = secondary_supply_fail_flags;
	wire [7:0] p = primary_supply_fail_flags;
	wire rst_any = srst | por_pulse | soft_reset_pulse;
	wire hit_s = cmd_word[6:0] == sff_pkg::ADDR_SECONDARY;
	wire hit_p = cmd_word[6:0] == sff_pkg::ADDR_PRIMARY;
	wire clr_s = cmd_valid & cmd_word[7] & hit_s;
	wire clr_p = cmd_valid & cmd_word[7] & hit_p;
	wire [7:0] sel = hit_s ? s : (hit_p ? p : 8'h00);
	wire restart = op_mode == sff_pkg::SFF_MODE_RESTART;
	wire sleep_off = (op_mode == sff_pkg::SFF_MODE_SLEEP) & ~main_reg_on;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst_any);
	// A detector held three cycles shows in its flag on the next edge.
	property p_latch(d, f);
		d [*3] |=> f;
	endproperty
	////////////////////////////////////////////////////////////////
	a_sec_reserved: assert property (!s[7] && !s[5])
		else $error("secondary reserved bit set");
	a_batt_latch: assert property (p_latch(det_batt_uv, s[6]))
		else $error("battery undervoltage not latched");
	a_r3uv_latch: assert property (p_latch(det_r3_uv, s[3]))
		else $error("third regulator undervoltage not latched");
	a_warn_latch: assert property (p_latch(det_main_prewarn, s[0]))
		else $error("prewarning not latched");
	a_hsuv_latch: assert property (p_latch(det_hs_uv, p[6]))
		else $error("highside undervoltage not latched");
	a_r2ot_latch: assert property (p_latch(det_r2_ot, p[4]))
		else $error("second regulator overtemp not latched");
	a_sec_sticky: assert property (!$past(rst_any) && !$past(clr_s) |-> ($past(s) & ~s) == 8'h00)
		else $error("secondary flag fell without clear");
	a_pri_sticky: assert property (!$past(rst_any) && !$past(clr_p) |-> ($past(p) & ~p & 8'hfd) == 8'h00)
		else $error("primary flag fell without clear");
	a_rsp_answer: assert property (cmd_valid |=> rsp_valid && rsp_data == $past(sel))
		else $error("answer missing or wrong");
	a_rsp_cause: assert property (rsp_valid |-> $past(cmd_valid))
		else $error("answer without command");
	a_por_value: assert property (disable iff (srst) por_pulse |=> p == sff_pkg::PRI_POR_RESET && s == 8'h00)
		else $error("power-on values wrong");
	a_soft_value: assert property (disable iff (srst || por_pulse) soft_reset_pulse |=> p == 8'h00 && s == 8'h00)
		else $error("soft reset values wrong");
	a_sleep_block: assert property ($past(sleep_off) |-> !$rose(p[0]) && !$rose(p[2]) && !$rose(s[1]))
		else $error("main flag set in sleep with regulator off");
	a_restart_clear: assert property (restart && !$past(restart) && !failsafe_uv_entry |=> !p[1])
		else $error("fail-safe flag kept on restart entry");
	a_fs_entry: assert property (failsafe_uv_entry |=> p[1])
		else $error("fail-safe entry not latched");
	// Main scenarios reached.
	cover property (clr_p ##1 rsp_valid);
	cover property (restart && !$past(restart));
	cover property ($rose(p[2]));
endmodule : sff_supply_flags_checker

bind sff_supply_flags sff_supply_flags_checker #(.SHORT_CYCLES(SHORT_CYCLES)) i_chk (.*);

// file: tb/tb.sv
`timescale 1ns/10ps
module tb;
	localparam int SC = 20;
	// Expected bytes for each detector, in the order of dv.
	localparam logic [7:0] ES [10] = '{8'h40, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] EP [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h20, 8'h10, 8'h08};
	localparam logic [2:0] MD [5] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h4};
	localparam logic [7:0] EU [5] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
	logic mclk = 1'h0, srst = 1'h1, por_pulse = 1'h0, soft_reset_pulse = 1'h0, cmd_valid = 1'h0;
	logic main_reg_on = 1'h1, reset_output_released = 1'h1, failsafe_uv_entry = 1'h0;
	logic det_main_uv = 1'h0;
	logic det_batt_uv, det_r3_oc, det_r3_uv, det_r3_ot, det_main_ov, det_main_prewarn;
	logic det_hs_uv, det_hs_ov, det_r2_ot, det_r2_uv, rsp_valid;
	logic [2:0] op_mode = 3'h1;
	logic [9:0] dv = '0;
	logic [15:0] cmd_word = '0;
	logic [7:0] rsp_data, secondary_supply_fail_flags, primary_supply_fail_flags;
	logic [7:0] q[$];
	int n_errors = 0, checks_done = 0, seed = 27, cyc = 0;
	assign {det_batt_uv, det_r3_oc, det_r3_uv, det_r3_ot, det_main_ov, det_main_prewarn,
		det_hs_uv, det_hs_ov, det_r2_ot, det_r2_uv} = dv;
	sff_supply_flags #(.SHORT_CYCLES(SC)) i_sff_supply_flags (.*);
	always #2 mclk = ~mclk;
	////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task report_and_stop;
		if (n_errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	// Issues one command and notes the answer it should get.
	task cmd(input logic [6:0] a, input logic c, input logic [7:0] e);
		@(posedge mclk);
		cmd_valid <= 1'h1;
		cmd_word <= {8'($random(seed)), c, a};
		q.push_back(e);
	endtask : cmd
	task idle(input int n);
		@(posedge mclk);
		cmd_valid <= 1'h0;
		repeat (n) @(posedge mclk);
	endtask : idle
	// Reads and clears both registers back to back.
	task rd2(input logic [7:0] es, input logic [7:0] ep);
		cmd(sff_pkg::ADDR_SECONDARY, 1'h1, es);
		cmd(sff_pkg::ADDR_PRIMARY, 1'h1, ep);
		idle(2);
	endtask : rd2
	// Compares each answer with the oldest note and cuts a hang short.
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc > 3000)
		begin
			n_errors++;
			report_and_stop();
		end
		if (rsp_valid === 1'h1)
			chk("rsp_data", rsp_data, (q.size() > 0) ? q.pop_front() : 8'hxx);
	end
	initial
	begin
		repeat (5) @(posedge mclk);
		srst <= 1'h0;
		cmd(7'h42, 1'h1, 8'h00);
		rd2(8'h00, 8'h80);
		for (int i = 0; i < 10; i++)
		begin
			@(posedge mclk);
			dv <= 10'h200 >> i;
			repeat (3 + ($random(seed) & 3)) @(posedge mclk);
			dv <= '0;
			idle(4);
			rd2(ES[i], EP[i]);
		end
		// A clear while the event persists leaves the flag set.
		@(posedge mclk);
		dv <= 10'h200;
		idle(4);
		cmd(7'h40, 1'h1, 8'h40);
		cmd(7'h40, 1'h1, 8'h40);
		idle(1);
		dv <= '0;
		idle(4);
		cmd(7'h40, 1'h1, 8'h40);
		cmd(7'h40, 1'h0, 8'h00);
		for (int m = 0; m < 5; m++)
		begin
			idle(1);
			op_mode <= MD[m];
			reset_output_released <= (m != 0);
			idle(2);
			det_main_uv <= 1'h1;
			repeat (4) @(posedge mclk);
			det_main_uv <= 1'h0;
			idle(4);
			cmd(7'h41, 1'h1, EU[m]);
		end
		// A long undervoltage in restart is a short and forces the flag.
		idle(1);
		det_main_uv <= 1'h1;
		repeat (SC + 10) @(posedge mclk);
		det_main_uv <= 1'h0;
		idle(4);
		cmd(7'h41, 1'h1, 8'h05);
		idle(1);
		op_mode <= sff_pkg::SFF_MODE_SLEEP;
		main_reg_on <= 1'h0;
		det_main_uv <= 1'h1;
		dv <= 10'h020;
		repeat (SC + 10) @(posedge mclk);
		det_main_uv <= 1'h0;
		dv <= '0;
		idle(4);
		rd2(8'h00, 8'h00);
		op_mode <= sff_pkg::SFF_MODE_NORMAL;
		main_reg_on <= 1'h1;
		failsafe_uv_entry <= 1'h1;
		dv <= 10'h008;
		@(posedge mclk);
		failsafe_uv_entry <= 1'h0;
		repeat (4) @(posedge mclk);
		dv <= '0;
		idle(3);
		cmd(7'h41, 1'h0, 8'h42);
		idle(1);
		op_mode <= sff_pkg::SFF_MODE_RESTART;
		idle(3);
		cmd(7'h41, 1'h1, 8'h40);
		idle(1);
		op_mode <= sff_pkg::SFF_MODE_NORMAL;
		dv <= 10'h200;
		repeat (4) @(posedge mclk);
		dv <= '0;
		idle(3);
		soft_reset_pulse <= 1'h1;
		@(posedge mclk);
		soft_reset_pulse <= 1'h0;
		idle(2);
		rd2(8'h00, 8'h00);
		por_pulse <= 1'h1;
		@(posedge mclk);
		por_pulse <= 1'h0;
		idle(2);
		rd2(8'h00, 8'h80);
		chk("pending", 8'(q.size()), 8'h00);
		chk("secondary_flags", secondary_supply_fail_flags, 8'h00);
		chk("primary_flags", primary_supply_fail_flags, 8'h00);
		report_and_stop();
	end
endmodule : tb
